// [design/slsi_pkg.sv]
// Package: register map, field positions, reset values and carriers for the link status block
package slsi_pkg;

    // ************************************************************
    // Register offsets (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [7:0] SLSI_CTRL_OFS = 8'h00; // Control bits steering the block
    localparam logic [7:0] SLSI_STAT_OFS = 8'h04; // Link status register
    localparam logic [7:0] SLSI_PRI_OFS = 8'h08; // Priority vector register
    localparam logic [7:0] SLSI_ISC_OFS = 8'h0c; // Interrupt status/clear register
    localparam logic [7:0] SLSI_EVT_OFS = 8'h10; // Event status, cleared by read
    localparam logic [7:0] SLSI_MSK_OFS = 8'h14; // Event mask

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SLSI_CTRL_SRST_BIT = 0; // Software reset of the port
    localparam int SLSI_CTRL_INTEN_BIT = 13; // Error interrupt enable
    localparam int SLSI_CTRL_LOCAL_BIT = 14; // Local interrupt select
    localparam int SLSI_STAT_REMOTE_BIT = 8; // Remote error flag
    localparam int SLSI_STAT_LOCAL_BIT = 7; // Local error flag
    localparam int SLSI_STAT_FIFO_LSB = 3; // Four FIFO non-empty bits, 6..3
    localparam int SLSI_STAT_SLAVE_REQUEST_PENDING_BIT = 2; // Slave request pending
    localparam int SLSI_STAT_MASTER_REQUEST_PENDING_BIT = 1; // Master request pending
    localparam int SLSI_STAT_LINK_BIT = 0; // Link up
    localparam int SLSI_PRI_NONE_BIT = 31; // None pending flag
    localparam int SLSI_EVT_W = 4; // Event bits: remote, local, link up, link down

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] SLSI_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SLSI_ISC_RST = 32'h0000_0000;
    localparam logic [SLSI_EVT_W-1:0] SLSI_EVT_RST = 4'h0;
    localparam logic [SLSI_EVT_W-1:0] SLSI_MSK_RST = 4'h0;

    // ************************************************************
    // Carriers
    // ************************************************************
    // Register port request from the host
    typedef struct packed {
        logic wr_stb;
        logic rd_stb;
        logic [7:0] addr;
        logic [31:0] wdata;
    } slsi_req_type;

    // Live link state from the port core, same clock
    typedef struct packed {
        logic [3:0] fifo_nonempty; // slave cmd, slave data, master cmd, master data
        logic slave_request_pending;
        logic master_request_pending;
        logic link_up;
    } slsi_link_type;

endpackage : slsi_pkg

// [design/slsi_regs.sv]
// Status, error flag, priority vector and interrupt registers of the serial link port
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// - Arriving error symbol sets remote error flag
// - Inbound packet error sets local error flag
// - Writing one clears either error flag
// - Error flag with enable raises port interrupt
// - Status bits 6..3 show FIFO non-empty
// - Status bit 2 shows slave request pending
// - Status bit 1 shows master request pending
// - Status bit 0 shows link up
// - Vector bit 31 high when nothing pending
// - Vector field gives lowest pending index
// - Vector write clears the named status bit
// - Vector bits 30..5 read zero
// - Interrupt status bits clear on write one
// - Status bit with local select raises interrupt
// - Software reset clears only the status register
module slsi_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire slsi_pkg::slsi_req_type req_in,
    output logic [31:0] rd_data_q,
    // Link core events and state
    input wire logic remote_err_in,
    input wire logic local_err_in,
    input wire slsi_pkg::slsi_link_type link_in,
    input wire logic [31:0] int_set_in,
    // Outputs to the core and the host
    output logic soft_reset_q,
    output logic port_interrupt_out_q,
    output logic sys_irq_q
);
    import slsi_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // Priority encoder
    // ************************************************************
    // Lowest set index wins; bit 0 is the most urgent
    function automatic logic [4:0] slsi_lowest(input logic [31:0] bits);
        logic [4:0] idx;
        idx = 5'h1f;
        for (int i = 31; i >= 0; i--) begin
            if (bits[i]) begin
                idx = i[4:0];
            end
        end
        return idx;
    endfunction : slsi_lowest

    // ************************************************************
    // State
    // ************************************************************
    logic inten_q; // Error interrupt enable
    logic local_interrupt_select_q; // Local interrupt select
    logic remote_error_flag_q; // Sticky remote error
    logic remote_error_flag_d;
    logic local_error_flag_q; // Sticky local error
    logic local_error_flag_d;
    logic [31:0] interrupt_status_bits_q; // Unmasked interrupt status
    logic [31:0] interrupt_status_bits_d;
    logic [SLSI_EVT_W-1:0] evt_q; // Sticky block events
    logic [SLSI_EVT_W-1:0] evt_d;
    logic [SLSI_EVT_W-1:0] msk_q; // Event mask
    logic link_prev_q; // Link level one cycle ago, for edges
    logic [31:0] status_prev_q; // Helper for the two vector register checks only

    // ************************************************************
    // Decode
    // ************************************************************
    wire wr_ctrl = req_in.wr_stb && (req_in.addr == SLSI_CTRL_OFS);
    wire wr_stat = req_in.wr_stb && (req_in.addr == SLSI_STAT_OFS);
    wire wr_pri = req_in.wr_stb && (req_in.addr == SLSI_PRI_OFS);
    wire wr_isc = req_in.wr_stb && (req_in.addr == SLSI_ISC_OFS);
    wire wr_msk = req_in.wr_stb && (req_in.addr == SLSI_MSK_OFS);
    wire rd_evt = req_in.rd_stb && (req_in.addr == SLSI_EVT_OFS);

    // Only the low five bits of a vector write matter
    wire [31:0] pri_clr = wr_pri ? (32'h0000_0001 << req_in.wdata[4:0]) : 32'h0;
    wire [31:0] isc_clr = wr_isc ? req_in.wdata : 32'h0;
    wire [31:0] clr_mask = pri_clr | isc_clr;

    // ************************************************************
    // Next values of the sticky flags
    // ************************************************************
    // A fresh event beats a software clear in the same cycle, so nothing is lost;
    // software reset beats both because it returns the status register to reset.
    wire rem_clr = wr_stat && req_in.wdata[SLSI_STAT_REMOTE_BIT];
    wire loc_clr = wr_stat && req_in.wdata[SLSI_STAT_LOCAL_BIT];
    assign remote_error_flag_d = soft_reset_q ? 1'b0 :
        (remote_error_flag_q && !rem_clr) || remote_err_in;
    assign local_error_flag_d = soft_reset_q ? 1'b0 :
        (local_error_flag_q && !loc_clr) || local_err_in;
    assign interrupt_status_bits_d = (interrupt_status_bits_q & ~clr_mask) | int_set_in;

    // Events: remote error, local error, link came up, link went down
    wire [SLSI_EVT_W-1:0] evt_set = {link_prev_q && !link_in.link_up,
        !link_prev_q && link_in.link_up, local_err_in, remote_err_in};
    wire [SLSI_EVT_W-1:0] evt_rclr = rd_evt ? {SLSI_EVT_W{1'b1}} : {SLSI_EVT_W{1'b0}};
    assign evt_d = (evt_q & ~evt_rclr) | evt_set;

    // ************************************************************
    // Read views
    // ************************************************************
    wire [31:0] ctrl_view = {17'h0, local_interrupt_select_q, inten_q, 12'h0, soft_reset_q};
    wire [31:0] stat_view = {23'h0, remote_error_flag_q, local_error_flag_q,
        link_in.fifo_nonempty,
        link_in.slave_request_pending,
        link_in.master_request_pending,
        link_in.link_up};
    wire any_pend = |interrupt_status_bits_q;
    // Vector field reads zero when nothing is pending; bits 30..5 are always zero
    wire [4:0] vec = any_pend ? slsi_lowest(interrupt_status_bits_q) : 5'h0;
    wire [31:0] pri_view = {!any_pend, 26'h0, vec};
    wire [31:0] evt_view = {{(32 - SLSI_EVT_W){1'b0}}, evt_q};
    wire [31:0] msk_view = {{(32 - SLSI_EVT_W){1'b0}}, msk_q};

    // Unmapped addresses read as zero
    wire [31:0] rd_mux = (req_in.addr == SLSI_CTRL_OFS) ? ctrl_view :
        (req_in.addr == SLSI_STAT_OFS) ? stat_view :
        (req_in.addr == SLSI_PRI_OFS) ? pri_view :
        (req_in.addr == SLSI_ISC_OFS) ? interrupt_status_bits_q :
        (req_in.addr == SLSI_EVT_OFS) ? evt_view :
        (req_in.addr == SLSI_MSK_OFS) ? msk_view : 32'h0;

    // Interrupt conditions
    wire err_cond = (remote_error_flag_q || local_error_flag_q) && inten_q;
    wire loc_cond = any_pend && local_interrupt_select_q;

    // ************************************************************
    // Control register
    // ************************************************************
    // Software reset stays set until software writes it back to zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            soft_reset_q <= SLSI_CTRL_RST[SLSI_CTRL_SRST_BIT];
            inten_q <= SLSI_CTRL_RST[SLSI_CTRL_INTEN_BIT];
            local_interrupt_select_q <= SLSI_CTRL_RST[SLSI_CTRL_LOCAL_BIT];
        end else if (wr_ctrl) begin
            soft_reset_q <= req_in.wdata[SLSI_CTRL_SRST_BIT];
            inten_q <= req_in.wdata[SLSI_CTRL_INTEN_BIT];
            local_interrupt_select_q <= req_in.wdata[SLSI_CTRL_LOCAL_BIT];
        end
    end

    // ************************************************************
    // Sticky flags
    // ************************************************************
    // Error flags and interrupt status bits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            remote_error_flag_q <= 1'b0;
            local_error_flag_q <= 1'b0;
            interrupt_status_bits_q <= SLSI_ISC_RST;
        end else begin
            remote_error_flag_q <= remote_error_flag_d;
            local_error_flag_q <= local_error_flag_d;
            interrupt_status_bits_q <= interrupt_status_bits_d;
        end
    end

    // Event status, mask and link edge tracker
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            evt_q <= SLSI_EVT_RST;
            msk_q <= SLSI_MSK_RST;
            link_prev_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            link_prev_q <= link_in.link_up;
            if (wr_msk) begin
                msk_q <= req_in.wdata[SLSI_EVT_W-1:0];
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Read data appears only in the cycle after the strobe; zero otherwise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data_q <= 32'h0;
        end else if (req_in.rd_stb) begin
            rd_data_q <= rd_mux;
        end else begin
            rd_data_q <= 32'h0;
        end
    end

    // Interrupt levels, one cycle behind the flags that cause them
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port_interrupt_out_q <= 1'b0;
            sys_irq_q <= 1'b0;
            status_prev_q <= 32'h0;
        end else begin
            port_interrupt_out_q <= err_cond || loc_cond;
            sys_irq_q <= |(evt_q & msk_q);
            status_prev_q <= interrupt_status_bits_q;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_remote_set: assert property (remote_err_in && !soft_reset_q |=> remote_error_flag_q)
        else $error("remote error event did not set its flag");

    a_local_set: assert property (local_err_in && !soft_reset_q |=> local_error_flag_q)
        else $error("local error event did not set its flag");

    a_err_w1c: assert property (rem_clr && !remote_err_in |=> !remote_error_flag_q)
        else $error("write one did not clear remote error flag");

    a_err_irq: assert property ((remote_error_flag_q || local_error_flag_q) && inten_q
        |=> port_interrupt_out_q)
        else $error("error flag with enable did not raise interrupt");

    a_fifo_read: assert property (req_in.rd_stb && req_in.addr == SLSI_STAT_OFS
        |=> rd_data_q[6:3] == $past(link_in.fifo_nonempty))
        else $error("fifo non-empty bits read wrong");

    a_slave_request_pending_read: assert property (req_in.rd_stb && req_in.addr == SLSI_STAT_OFS
        |=> rd_data_q[SLSI_STAT_SLAVE_REQUEST_PENDING_BIT] == $past(link_in.slave_request_pending))
        else $error("slave pending bit read wrong");

    a_master_request_pending_read: assert property (req_in.rd_stb && req_in.addr == SLSI_STAT_OFS
        |=> rd_data_q[SLSI_STAT_MASTER_REQUEST_PENDING_BIT] == $past(link_in.master_request_pending))
        else $error("master pending bit read wrong");

    a_link_read: assert property (req_in.rd_stb && req_in.addr == SLSI_STAT_OFS
        |=> rd_data_q[SLSI_STAT_LINK_BIT] == $past(link_in.link_up))
        else $error("link bit read wrong");

    a_none_pend: assert property (req_in.rd_stb && req_in.addr == SLSI_PRI_OFS
        |=> rd_data_q[SLSI_PRI_NONE_BIT] == (status_prev_q == 32'h0))
        else $error("none pending flag wrong");

    a_vector_lowest: assert property (req_in.rd_stb && req_in.addr == SLSI_PRI_OFS && any_pend
        |=> status_prev_q[rd_data_q[4:0]]
        && ((status_prev_q & ((32'h1 << rd_data_q[4:0]) - 32'h1)) == 32'h0))
        else $error("vector is not the lowest pending index");

    a_vector_clear: assert property (wr_pri && !int_set_in[req_in.wdata[4:0]]
        |=> !interrupt_status_bits_q[$past(req_in.wdata[4:0])])
        else $error("vector write did not clear its bit");

    a_pri_reserved: assert property (req_in.rd_stb && req_in.addr == SLSI_PRI_OFS
        |=> rd_data_q[30:5] == 26'h0)
        else $error("reserved vector bits not zero");

    a_isc_w1c: assert property (wr_isc
        |=> (interrupt_status_bits_q & $past(req_in.wdata & ~int_set_in)) == 32'h0)
        else $error("write one did not clear interrupt status");

    a_local_irq: assert property (any_pend && local_interrupt_select_q |=> port_interrupt_out_q)
        else $error("local interrupt not raised");

    a_soft_reset: assert property (soft_reset_q
        |=> !remote_error_flag_q && !local_error_flag_q)
        else $error("software reset handling wrong");

    a_flag_hold: assert property (local_error_flag_q && !loc_clr && !soft_reset_q
        |=> local_error_flag_q)
        else $error("local error flag dropped by itself");

    a_irq_or: assert property (##1 port_interrupt_out_q == $past(err_cond || loc_cond))
        else $error("interrupt output is not the OR of its conditions");

    // ************************************************************
    // Assertions: holds, clears, bus shape and events
    // ************************************************************
    // Each $past term is the state one edge back, so these checks ride the
    // same one-cycle latency as the registers they watch.
    a_local_w1c: assert property (loc_clr && !local_err_in |=> !local_error_flag_q)
        else $error("write one did not clear local error flag");

    a_remote_hold: assert property (remote_error_flag_q && !rem_clr && !soft_reset_q
        |=> remote_error_flag_q)
        else $error("remote error flag dropped by itself");

    a_isc_hold: assert property ((interrupt_status_bits_q & ~clr_mask) != 32'h0
        |=> (interrupt_status_bits_q & $past(interrupt_status_bits_q & ~clr_mask))
        == $past(interrupt_status_bits_q & ~clr_mask))
        else $error("interrupt status bit dropped by itself");

    a_isc_set: assert property (int_set_in != 32'h0
        |=> (interrupt_status_bits_q & $past(int_set_in)) == $past(int_set_in))
        else $error("interrupt status bit not set by its event");

    a_vector_only: assert property (wr_pri
        |=> ((interrupt_status_bits_q ^ $past(interrupt_status_bits_q | int_set_in))
        & ~$past(pri_clr)) == 32'h0)
        else $error("vector write touched other status bits");

    a_srst_mask: assert property (soft_reset_q && !wr_msk |=> $stable(msk_q))
        else $error("software reset disturbed the event mask");

    a_srst_ctrl: assert property (soft_reset_q && !wr_ctrl
        |=> $stable(inten_q) && $stable(local_interrupt_select_q))
        else $error("software reset disturbed the control bits");

    a_irq_quiet: assert property (!err_cond && !loc_cond |=> !port_interrupt_out_q)
        else $error("interrupt raised with no condition");

    a_rd_idle: assert property (!req_in.rd_stb |=> rd_data_q == 32'h0)
        else $error("read data not zero outside the read cycle");

    a_err_read: assert property (req_in.rd_stb && req_in.addr == SLSI_STAT_OFS
        |=> rd_data_q[SLSI_STAT_REMOTE_BIT:SLSI_STAT_LOCAL_BIT]
        == $past({remote_error_flag_q, local_error_flag_q}))
        else $error("error flag bits read wrong");

    a_stat_reserved: assert property (req_in.rd_stb && req_in.addr == SLSI_STAT_OFS
        |=> rd_data_q[31:9] == 23'h0)
        else $error("reserved status bits not zero");

    a_pri_idle: assert property (req_in.rd_stb && req_in.addr == SLSI_PRI_OFS && !any_pend
        |=> rd_data_q == 32'h8000_0000)
        else $error("empty vector read wrong");

    a_ctrl_read: assert property (req_in.rd_stb && req_in.addr == SLSI_CTRL_OFS
        |=> rd_data_q[SLSI_CTRL_LOCAL_BIT:SLSI_CTRL_INTEN_BIT] == $past({local_interrupt_select_q, inten_q}))
        else $error("control enable bits read wrong");

    a_evt_set: assert property (evt_set != 4'h0
        |=> (evt_q & $past(evt_set)) == $past(evt_set))
        else $error("event did not set its status bit");

    a_evt_rclr: assert property (rd_evt |=> evt_q == $past(evt_set))
        else $error("event read did not clear old events");

    a_sys_irq: assert property (##1 sys_irq_q == $past(|(evt_q & msk_q)))
        else $error("event interrupt does not follow masked events");

endmodule : slsi_regs

// [verification/slsi_peer_model.sv]
// Behavioural model of the link core that feeds events and live state
`timescale 1ns/1ps
module slsi_peer_model (
    // Clock
    input wire logic core_clk,
    // Events and live state toward the register block
    output logic remote_err_in,
    output logic local_err_in,
    output slsi_pkg::slsi_link_type link_in,
    output logic [31:0] int_set_in
);
    import slsi_pkg::*;

    // Quiet link at time zero: no events, link down, FIFOs empty
    initial begin
        remote_err_in = 1'b0;
        local_err_in = 1'b0;
        link_in = '0;
        int_set_in = 32'h0;
    end

    // One-cycle event pulse; the wait up front keeps two pulses from sharing an edge
    task automatic pulse(input logic r, input logic l, input logic [31:0] s);
        @(posedge core_clk);
        remote_err_in <= r;
        local_err_in <= l;
        int_set_in <= s;
        @(posedge core_clk);
        remote_err_in <= 1'b0;
        local_err_in <= 1'b0;
        int_set_in <= 32'h0;
    endtask : pulse

    // Live state moves just after an edge and then holds
    task automatic set_link(input slsi_link_type v);
        @(posedge core_clk);
        link_in <= v;
    endtask : set_link
endmodule : slsi_peer_model

// [verification/test_slsi_regs.sv]
// Self-checking bench for the link status and interrupt registers
`timescale 1ns/1ps
module test_slsi_regs;
    import slsi_pkg::*;

    // ************************************************************
    // Hookup and reference state
    // ************************************************************
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    slsi_req_type req = '0;
    logic [31:0] rd_data_q;
    logic rem_err, loc_err, soft_rst, port_irq, sys_irq;
    slsi_link_type link;
    logic [31:0] int_set;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    // Reference: error flags, interrupt status, control, events, mask
    logic m_rem = 1'b0;
    logic m_loc = 1'b0;
    logic [31:0] m_isc = 32'h0;
    logic [31:0] m_ctrl = 32'h0;
    logic [3:0] m_evt = 4'h0;
    logic [3:0] m_msk = 4'h0;
    slsi_link_type m_link = '0;

    slsi_regs i_slsi_regs (.core_clk(core_clk), .rst_n(rst_n), .req_in(req),
        .rd_data_q(rd_data_q), .remote_err_in(rem_err), .local_err_in(loc_err),
        .link_in(link), .int_set_in(int_set), .soft_reset_q(soft_rst),
        .port_interrupt_out_q(port_irq), .sys_irq_q(sys_irq));
    slsi_peer_model i_slsi_peer_model (.core_clk(core_clk), .remote_err_in(rem_err),
        .local_err_in(loc_err), .link_in(link), .int_set_in(int_set));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // Hang guard: generous against the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Strobes rise after a fresh edge, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{wr_stb: 1'b1, rd_stb: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req.wr_stb <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        req <= '{wr_stb: 1'b0, rd_stb: 1'b1, addr: a, wdata: 32'h0};
        @(posedge core_clk);
        req.rd_stb <= 1'b0;
        #1 d = rd_data_q;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        rd(a, d);
        chk(name, d, exp);
    endtask : rchk

    function automatic logic [31:0] exp_stat();
        return {23'h0, m_rem, m_loc, m_link.fifo_nonempty, m_link.slave_request_pending,
            m_link.master_request_pending, m_link.link_up};
    endfunction : exp_stat

    // Lowest set index wins; all clear reports the none-pending flag alone
    function automatic logic [31:0] exp_pri();
        for (int i = 0; i < 32; i++) begin
            if (m_isc[i]) return {27'h0, i[4:0]};
        end
        return 32'h8000_0000;
    endfunction : exp_pri

    // Outputs are levels one cycle behind their cause; three idle cycles settle them
    task automatic chk_irq();
        repeat (3) @(posedge core_clk);
        #1;
        chk("port_irq", {31'h0, port_irq},
            {31'h0, (m_ctrl[13] & (m_rem | m_loc)) | (m_ctrl[14] & (|m_isc))});
        chk("sys_irq", {31'h0, sys_irq}, {31'h0, |(m_evt & m_msk)});
    endtask : chk_irq

    // Link edges are events as well
    task automatic upd_link(input slsi_link_type v);
        m_evt[2] = m_evt[2] | (~m_link.link_up & v.link_up);
        m_evt[3] = m_evt[3] | (m_link.link_up & ~v.link_up);
        m_link = v;
        i_slsi_peer_model.set_link(v);
    endtask : upd_link

    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] d, v, e;
        void'($urandom(73042));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values; an unmapped write must leave no trace
        wr(8'h18, 32'hffff_ffff);
        rchk(SLSI_CTRL_OFS, 32'h0, "ctrl");
        rchk(SLSI_STAT_OFS, exp_stat(), "stat");
        rchk(SLSI_PRI_OFS, 32'h8000_0000, "pri");
        rchk(SLSI_ISC_OFS, 32'h0, "isc");
        rchk(SLSI_EVT_OFS, 32'h0, "evt");
        rchk(SLSI_MSK_OFS, 32'h0, "msk");
        rchk(8'h18, 32'h0, "unmapped");
        // Live FIFO, pending and link bits under random state
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            v[0] = i[0];
            upd_link(v[6:0]);
            rchk(SLSI_STAT_OFS, exp_stat(), "stat live");
        end
        // Error flags: set, hold through zero writes, clear one at a time
        wr(SLSI_CTRL_OFS, 32'h0000_2000);
        m_ctrl = 32'h0000_2000;
        i_slsi_peer_model.pulse(1'b1, 1'b0, 32'h0);
        m_rem = 1'b1;
        m_evt[0] = 1'b1;
        chk_irq();
        i_slsi_peer_model.pulse(1'b0, 1'b1, 32'h0);
        m_loc = 1'b1;
        m_evt[1] = 1'b1;
        wr(SLSI_STAT_OFS, 32'hffff_fe7f);
        rchk(SLSI_STAT_OFS, exp_stat(), "stat both");
        wr(SLSI_STAT_OFS, 32'h0000_0100);
        m_rem = 1'b0;
        rchk(SLSI_STAT_OFS, exp_stat(), "stat rem clr");
        chk_irq();
        wr(SLSI_STAT_OFS, 32'h0000_0080);
        m_loc = 1'b0;
        rchk(SLSI_STAT_OFS, exp_stat(), "stat loc clr");
        chk_irq();
        // Interrupt status: set, write-one clear, drain by vector
        wr(SLSI_CTRL_OFS, 32'h0000_4000);
        m_ctrl = 32'h0000_4000;
        v = $urandom | 32'h8000_0001;
        i_slsi_peer_model.pulse(1'b0, 1'b0, v);
        m_isc = v;
        chk_irq();
        rchk(SLSI_ISC_OFS, m_isc, "isc set");
        d = $urandom;
        wr(SLSI_ISC_OFS, d);
        m_isc = m_isc & ~d;
        rchk(SLSI_ISC_OFS, m_isc, "isc w1c");
        while (m_isc != 32'h0) begin
            e = exp_pri();
            rchk(SLSI_PRI_OFS, e, "pri vec");
            v = $urandom;
            wr(SLSI_PRI_OFS, {v[31:5], e[4:0]});
            m_isc[e[4:0]] = 1'b0;
        end
        rchk(SLSI_PRI_OFS, 32'h8000_0000, "pri empty");
        chk_irq();
        i_slsi_peer_model.pulse(1'b0, 1'b0, 32'h8000_0000);
        m_isc = 32'h8000_0000;
        rchk(SLSI_PRI_OFS, 32'h0000_001f, "pri last");
        wr(SLSI_PRI_OFS, 32'hffff_ffff);
        m_isc = 32'h0;
        rchk(SLSI_ISC_OFS, 32'h0, "isc last");
        // Event status and mask: read clears, mask gates the event interrupt
        wr(SLSI_MSK_OFS, 32'h0000_000f);
        m_msk = 4'hf;
        chk_irq();
        rchk(SLSI_EVT_OFS, {28'h0, m_evt}, "evt");
        m_evt = 4'h0;
        chk_irq();
        wr(SLSI_MSK_OFS, 32'h0000_0001);
        m_msk = 4'h1;
        rchk(SLSI_MSK_OFS, 32'h0000_0001, "msk");
        i_slsi_peer_model.pulse(1'b0, 1'b1, 32'h0);
        m_loc = 1'b1;
        m_evt[1] = 1'b1;
        chk_irq();
        i_slsi_peer_model.pulse(1'b1, 1'b0, 32'h0);
        m_rem = 1'b1;
        m_evt[0] = 1'b1;
        chk_irq();
        // Software reset clears only the flags, and holds them against new errors
        wr(SLSI_MSK_OFS, 32'h0);
        m_msk = 4'h0;
        i_slsi_peer_model.pulse(1'b0, 1'b0, 32'h0000_0010);
        m_isc = 32'h0000_0010;
        wr(SLSI_CTRL_OFS, 32'h0000_2001);
        m_ctrl = 32'h0000_2001;
        m_rem = 1'b0;
        m_loc = 1'b0;
        i_slsi_peer_model.pulse(1'b1, 1'b1, 32'h0);
        m_evt[1:0] = 2'b11;
        rchk(SLSI_STAT_OFS, exp_stat(), "stat srst");
        rchk(SLSI_ISC_OFS, 32'h0000_0010, "isc srst");
        chk("soft_rst", {31'h0, soft_rst}, 32'h1);
        chk_irq();
        rchk(SLSI_EVT_OFS, {28'h0, m_evt}, "evt srst");
        m_evt = 4'h0;
        wr(SLSI_CTRL_OFS, 32'h0);
        final_report();
    end
endmodule : test_slsi_regs
